// ===== radio_spi_pkg.sv
// Purpose: Shared constants and types of the radio serial-port block.
// Assumes: Serial-port mode 0, header byte sent MSB first.
// Notes:   All offsets, field positions, reset values and counts live here.
// Functional notes
// - Address 0x3F reaches buffers; write bit selects transmit, read receive; 64 bytes each.
// - Transmit buffer is write-only; receive buffer is read-only.
// - Single access is header plus one data byte, then a new header.
// - Burst access streams data bytes until chip-select rises.
// - Headers 0x3F, 0x7F, 0xBF, 0xFF are single/burst transmit, single/burst receive.
// - Status byte is returned per written byte, free count before storing it.
// - Last byte that fits reports exactly one free byte.
// - Flush strobes empty buffers; allowed only in idle, underrun or overrun.
// - Entering sleep empties both buffers.
// - Address 0x3E reaches the power table, eight entries; a burst past eight data bytes wraps to entry 0.
// - Power table has eight entries, active one picked by three-bit index.
// - Table index advances per byte, wraps 7 to 0, zero while deselected.
// - Burst bit picks single/burst, read bit picks read/write for the table.
// - Sleep keeps table entry 0 and clears all others.
// - Shared pin is serial output whenever selected, else status or released.
// - In serial modes the first general pin feeds transmit data while transmitting.
// - Three-pin state control works only when its enable bit is set.
// - Select falling edge latches clock and input: 00 down, 01 tx, 10 idle, 11 rx.
// - A pin strobe only changes state; same target restarts nothing.
// - Pin strobes act at once, power-down waits for chip-select high.
// - Deselected pins do nothing; selection wakes sleep or oscillator-off into idle, or into tx or rx when a pin strobe picks it.
// - Header is read bit, burst bit, six address bits; address is held for the whole access.
// - Status bits 6 to 4 carry state; 110 overrun, 111 underrun.
// - Status byte count field saturates at 15.
package radio_spi_pkg;

  // ----------------------------------------
  // Addresses and header layout
  // ----------------------------------------
  localparam logic [5:0] FIFO_ADDR    = 6'h3f;
  localparam logic [5:0] PA_ADDR      = 6'h3e;
  localparam int         HDR_RW_BIT   = 7;
  localparam int         HDR_BURST_BIT = 6;
  localparam logic [7:0] HDR_TX_SINGLE = 8'h3f;
  localparam logic [7:0] HDR_TX_BURST  = 8'h7f;
  localparam logic [7:0] HDR_RX_SINGLE = 8'hbf;
  localparam logic [7:0] HDR_RX_BURST  = 8'hff;

  // ----------------------------------------
  // Buffer, table and status sizing
  // ----------------------------------------
  localparam int         FIFO_DEPTH = 64;
  localparam int         PTR_W      = 6;
  localparam int         CNT_W      = 7;
  localparam logic [6:0] FIFO_FULL  = 7'h40;
  localparam int         PA_ENTRIES = 8;
  localparam logic [7:0] PA_RESET   = 8'h00;
  localparam logic [6:0] COUNT_SAT  = 7'h0f;
  localparam logic [2:0] PA_IDX_LAST = 3'h7;

  // ----------------------------------------
  // Main states; low three bits are the status code
  // ----------------------------------------
  typedef enum logic [3:0] {
    IDLE_ST  = 4'b0000,
    RX_ST    = 4'b0001,
    TX_ST    = 4'b0010,
    OVR_ST   = 4'b0110,
    UND_ST   = 4'b0111,
    SLEEP_ST = 4'b1000,
    OSCILLATOR_OFF_STATE_ST  = 4'b1001
  } radio_state_e;

  // Pin-control codes, clock then input
  localparam logic [1:0] PIN_PD   = 2'b00;
  localparam logic [1:0] PIN_TX   = 2'b01;
  localparam logic [1:0] PIN_IDLE = 2'b10;
  localparam logic [1:0] PIN_RX   = 2'b11;

endpackage

// ===== radio_spi_port.sv
// Purpose: Serial-port buffer, power-table and pin-control logic of the radio.
// Assumes: Serial pins are asynchronous and pass two flip-flops first.
// Notes:   Registers other than 0x3E/0x3F are outside this block; such
//          headers are consumed and the next byte is a fresh header.

// ----------------------------------------
// Byte ring buffer
// ----------------------------------------
module byte_ring
  import radio_spi_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clear,
  input  wire logic             push,
  input  wire logic [7:0]       push_data,
  input  wire logic             pop,
  output logic      [7:0]       pop_data,
  output logic      [CNT_W-1:0] count,
  output logic      [CNT_W-1:0] count_next
);
  logic [7:0]       mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] cnt_reg;

  // Callers never push when full nor pop when empty
  always_comb begin
    count_next = cnt_reg;
    if (clear) begin
      count_next = '0;
    end else if (push && !pop) begin
      count_next = cnt_reg + 7'd1;
    end else if (pop && !push) begin
      count_next = cnt_reg - 7'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 6'd1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 6'd1;
      end
      cnt_reg <= count_next;
    end
  end

  // Storage needs no reset
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= push_data;
    end
  end

  assign pop_data = mem[rd_ptr_reg];
  assign count    = cnt_reg;
endmodule // byte_ring

// ----------------------------------------
// Top level
// ----------------------------------------
module radio_spi_port
  import radio_spi_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       sclk_pin,
  input  wire logic       si_pin,
  input  wire logic       chip_select_low,
  output logic            shared_status_pin_out,
  output logic            shared_status_pin_oe,
  input  wire logic       status_pin_en,
  input  wire logic       status_pin_level,
  input  wire logic       pin_ctrl_en,
  input  wire logic       serial_mode_en,
  input  wire logic       general_pin_a,
  output logic            serial_tx_bit,
  input  wire logic [2:0] output_power_index,
  output logic      [7:0] pa_setting,
  input  wire logic       flush_tx_strobe,
  input  wire logic       flush_rx_strobe,
  input  wire logic       sleep_req,
  input  wire logic       osc_off_req,
  output logic      [7:0] tx_out_data,
  output logic            tx_out_valid,
  input  wire logic       tx_out_ready,
  input  wire logic [7:0] rx_in_data,
  input  wire logic       rx_in_valid,
  output logic            rx_in_ready,
  output logic      [3:0] radio_state,
  output logic            chip_ready_low
);
  logic [1:0]       sclk_sync_reg, si_sync_reg, cs_sync_reg, gpa_sync_reg;
  logic             sclk_prev_reg, cs_prev_reg;
  logic             sclk_s, si_s, cs_active, sclk_rise, cs_fall, cs_rise;
  logic [2:0]       bit_cnt_reg;
  logic [7:0]       shift_in_reg, so_reg, so_next, byte_in;
  logic             data_phase_reg, rw_reg, burst_reg, tgt_fifo_reg, tgt_pa_reg;
  logic             byte_done, hdr_done, data_done, next_data, rw_now;
  logic             tgt_fifo_now, tgt_pa_now, load_rx, load_pa, pa_wr;
  logic [2:0]       pa_idx_reg;
  logic [7:0]       pa_table [PA_ENTRIES];
  radio_state_e     state_reg, state_next;
  logic             pd_pend_reg, pin_cmd, sleep_enter, flush_ok;
  logic             flush_tx_do, flush_rx_do, tx_und_evt, rx_ovr_evt;
  logic             tx_push, tx_pop, rx_push, rx_pop, tx_clear, rx_clear;
  logic [7:0]       tx_head, rx_head;
  logic [CNT_W-1:0] tx_cnt, tx_cnt_next, rx_cnt, rx_cnt_next, cnt_view;
  logic [7:0]       ob_data_reg [2];
  logic [1:0]       ob_cnt_reg;
  logic             ob_pop;

  // ----------------------------------------
  // Pin synchronisers and edge finders
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclk_sync_reg <= 2'b00;
      si_sync_reg   <= 2'b00;
      cs_sync_reg   <= 2'b11;
      gpa_sync_reg  <= 2'b00;
      sclk_prev_reg <= 1'b0;
      cs_prev_reg   <= 1'b1;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[0], sclk_pin};
      si_sync_reg   <= {si_sync_reg[0], si_pin};
      cs_sync_reg   <= {cs_sync_reg[0], chip_select_low};
      gpa_sync_reg  <= {gpa_sync_reg[0], general_pin_a};
      sclk_prev_reg <= sclk_sync_reg[1];
      cs_prev_reg   <= cs_sync_reg[1];
    end
  end

  assign sclk_s    = sclk_sync_reg[1];
  assign si_s      = si_sync_reg[1];
  assign cs_active = !cs_sync_reg[1];
  // Clock edges count only while selected
  assign sclk_rise = sclk_s && !sclk_prev_reg && cs_active;
  assign cs_fall   = cs_active && cs_prev_reg;
  assign cs_rise   = !cs_active && !cs_prev_reg;

  // ----------------------------------------
  // Header decode and byte framing
  // ----------------------------------------
  always_comb begin
    byte_in      = {shift_in_reg[6:0], si_s};
    byte_done    = sclk_rise && (bit_cnt_reg == 3'd7);
    hdr_done     = byte_done && !data_phase_reg;
    data_done    = byte_done && data_phase_reg;
    tgt_fifo_now = hdr_done ? (byte_in[5:0] == FIFO_ADDR) : tgt_fifo_reg;
    tgt_pa_now   = hdr_done ? (byte_in[5:0] == PA_ADDR) : tgt_pa_reg;
    rw_now       = hdr_done ? byte_in[HDR_RW_BIT] : rw_reg;
    next_data    = data_phase_reg;
    if (hdr_done) begin
      next_data = tgt_fifo_now || tgt_pa_now;
    end else if (data_done) begin
      next_data = burst_reg;
    end
    load_rx  = byte_done && next_data && tgt_fifo_now && rw_now;
    load_pa  = byte_done && next_data && tgt_pa_now && rw_now;
    pa_wr    = data_done && tgt_pa_reg && !rw_reg;
    // Only writes reach transmit, only reads drain receive
    tx_push  = data_done && tgt_fifo_reg && !rw_reg && (tx_cnt != FIFO_FULL);
    rx_pop   = load_rx && (rx_cnt != '0);
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !cs_active) begin
      bit_cnt_reg    <= 3'd0;
      shift_in_reg   <= 8'h00;
      data_phase_reg <= 1'b0;
      rw_reg         <= 1'b0;
      burst_reg      <= 1'b0;
      tgt_fifo_reg   <= 1'b0;
      tgt_pa_reg     <= 1'b0;
    end else if (sclk_rise) begin
      bit_cnt_reg    <= bit_cnt_reg + 3'd1;
      shift_in_reg   <= byte_in;
      data_phase_reg <= next_data;
      if (hdr_done) begin
        rw_reg       <= byte_in[HDR_RW_BIT];
        burst_reg    <= byte_in[HDR_BURST_BIT];
        tgt_fifo_reg <= tgt_fifo_now;
        tgt_pa_reg   <= tgt_pa_now;
      end
    end
  end

  // ----------------------------------------
  // Serial output: status byte or read data
  // ----------------------------------------
  // Free space is taken after this cycle's store, i.e. before the next byte
  always_comb begin
    cnt_view = rw_now ? rx_cnt_next : (FIFO_FULL - tx_cnt_next);
    so_next  = {chip_ready_low, state_reg[2:0],
                (cnt_view > COUNT_SAT) ? 4'hf : cnt_view[3:0]};
    if (load_rx) begin
      so_next = (rx_cnt != '0) ? rx_head : 8'h00;
    end else if (load_pa) begin
      so_next = pa_table[pa_idx_reg];
    end
  end

  // Output changes just after the sampling edge, ready for the next one
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      so_reg <= 8'h00;
    end else if (cs_fall || byte_done) begin
      so_reg <= so_next;
    end else if (sclk_rise) begin
      so_reg <= {so_reg[6:0], 1'b0};
    end
  end

  // Pin is always the serial output while selected
  assign shared_status_pin_oe  = cs_active || status_pin_en;
  assign shared_status_pin_out = cs_active ? so_reg[7] : status_pin_level;

  // ----------------------------------------
  // Power table
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n || !cs_active) begin
      pa_idx_reg <= 3'd0;
    end else if (pa_wr || load_pa) begin
      pa_idx_reg <= pa_idx_reg + 3'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < PA_ENTRIES; i++) begin
        pa_table[i] <= PA_RESET;
      end
      pa_setting <= PA_RESET;
    end else begin
      if (sleep_enter) begin
        for (int i = 1; i < PA_ENTRIES; i++) begin
          pa_table[i] <= PA_RESET;
        end
      end else if (pa_wr) begin
        pa_table[pa_idx_reg] <= byte_in;
      end
      pa_setting <= pa_table[output_power_index];
    end
  end

  // ----------------------------------------
  // Main state and pin control
  // ----------------------------------------
  always_comb begin
    flush_ok    = (state_reg == IDLE_ST) || (state_reg == UND_ST) || (state_reg == OVR_ST);
    flush_tx_do = flush_tx_strobe && flush_ok;
    flush_rx_do = flush_rx_strobe && flush_ok;
    tx_und_evt  = (state_reg == TX_ST) && tx_out_ready && !tx_out_valid && (tx_cnt == '0);
    rx_ovr_evt  = (state_reg == RX_ST) && rx_in_valid && (rx_cnt == FIFO_FULL);
    pin_cmd     = cs_fall && pin_ctrl_en;
    state_next  = state_reg;
    if (cs_active && (state_reg == SLEEP_ST || state_reg == OSCILLATOR_OFF_STATE_ST)) begin
      state_next = IDLE_ST;
    end
    if (tx_und_evt) begin
      state_next = UND_ST;
    end
    if (rx_ovr_evt) begin
      state_next = OVR_ST;
    end
    if ((flush_tx_do && state_reg == UND_ST) || (flush_rx_do && state_reg == OVR_ST)) begin
      state_next = IDLE_ST;
    end
    // Equal target leaves the state untouched, so nothing restarts
    if (pin_cmd) begin
      case ({sclk_s, si_s})
        PIN_TX:   if (state_reg != TX_ST) state_next = TX_ST;
        PIN_IDLE: if (state_reg != IDLE_ST) state_next = IDLE_ST;
        PIN_RX:   if (state_reg != RX_ST) state_next = RX_ST;
        default:  state_next = state_next;
      endcase
    end
    // Power-down only lands once deselected
    if ((pd_pend_reg && cs_rise) || (sleep_req && !cs_active)) begin
      state_next = SLEEP_ST;
    end else if (osc_off_req && !cs_active) begin
      state_next = OSCILLATOR_OFF_STATE_ST;
    end
    sleep_enter = (state_next == SLEEP_ST) && (state_reg != SLEEP_ST);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg   <= IDLE_ST;
      pd_pend_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (cs_rise) begin
        pd_pend_reg <= 1'b0;
      end else if (pin_cmd && ({sclk_s, si_s} == PIN_PD)) begin
        pd_pend_reg <= 1'b1;
      end
    end
  end

  assign radio_state    = state_reg;
  assign chip_ready_low = (state_reg == SLEEP_ST) || (state_reg == OSCILLATOR_OFF_STATE_ST);

  // Serial transmit data from the first general pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      serial_tx_bit <= 1'b0;
    end else begin
      serial_tx_bit <= serial_mode_en && (state_reg == TX_ST) && gpa_sync_reg[1];
    end
  end

  // ----------------------------------------
  // Buffers and two-entry output stage
  // ----------------------------------------
  assign tx_clear    = flush_tx_do || sleep_enter;
  assign rx_clear    = flush_rx_do || sleep_enter;
  assign rx_in_ready = (state_reg == RX_ST) && (rx_cnt != FIFO_FULL);
  assign rx_push     = rx_in_valid && rx_in_ready;
  // Stalls in the radio side back up into the ring, so no byte is lost
  assign tx_pop      = (state_reg == TX_ST) && (tx_cnt != '0) && (ob_cnt_reg != 2'd2);
  assign ob_pop      = tx_out_valid && tx_out_ready;

  byte_ring tx_ring (
    .clk        (clk),
    .rst_n      (rst_n),
    .clear      (tx_clear),
    .push       (tx_push),
    .push_data  (byte_in),
    .pop        (tx_pop),
    .pop_data   (tx_head),
    .count      (tx_cnt),
    .count_next (tx_cnt_next)
  );

  byte_ring rx_ring (
    .clk        (clk),
    .rst_n      (rst_n),
    .clear      (rx_clear),
    .push       (rx_push),
    .push_data  (rx_in_data),
    .pop        (rx_pop),
    .pop_data   (rx_head),
    .count      (rx_cnt),
    .count_next (rx_cnt_next)
  );

  always_ff @(posedge clk) begin
    if (!rst_n || tx_clear) begin
      ob_cnt_reg     <= 2'd0;
      ob_data_reg[0] <= 8'h00;
      ob_data_reg[1] <= 8'h00;
    end else if (tx_pop && !ob_pop) begin
      ob_data_reg[ob_cnt_reg[0]] <= tx_head;
      ob_cnt_reg <= ob_cnt_reg + 2'd1;
    end else if (ob_pop && !tx_pop) begin
      ob_data_reg[0] <= ob_data_reg[1];
      ob_cnt_reg <= ob_cnt_reg - 2'd1;
    end else if (ob_pop && tx_pop) begin
      ob_data_reg[0] <= (ob_cnt_reg == 2'd1) ? tx_head : ob_data_reg[1];
      ob_data_reg[1] <= tx_head;
    end
  end

  assign tx_out_valid = (ob_cnt_reg != 2'd0);
  assign tx_out_data  = ob_data_reg[0];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_idx_clear;
    !cs_active |=> (pa_idx_reg == 3'd0);
  endproperty
  a_idx_clear: assert property (p_idx_clear) else $error("table index not zero");

  property p_idx_wrap;
    (cs_active && pa_wr && pa_idx_reg == PA_IDX_LAST) ##1 cs_active |-> (pa_idx_reg == 3'd0);
  endproperty
  a_idx_wrap: assert property (p_idx_wrap) else $error("table index did not wrap");

  property p_tx_write_only;
    tx_push |-> !rw_reg && tgt_fifo_reg && data_phase_reg;
  endproperty
  a_tx_write_only: assert property (p_tx_write_only) else $error("bad transmit store");

  property p_rx_no_spi_write;
    (rx_cnt != FIFO_FULL) && (rx_cnt > 7'd0) ##1 (rx_cnt > $past(rx_cnt)) |-> $past(rx_push);
  endproperty
  a_rx_no_spi_write: assert property (p_rx_no_spi_write) else $error("receive grew");

  // A byte dropped on a full buffer must still report no free space
  property p_none_free;
    (data_done && tgt_fifo_reg && !rw_reg && burst_reg && tx_cnt == FIFO_FULL && !tx_pop)
      |=> (so_reg[3:0] == 4'h0);
  endproperty
  a_none_free: assert property (p_none_free) else $error("full buffer not reported");

  property p_last_fits;
    (data_done && tgt_fifo_reg && !rw_reg && burst_reg && tx_cnt == 7'd62 && !tx_pop)
      |=> (so_reg[3:0] == 4'h1);
  endproperty
  a_last_fits: assert property (p_last_fits) else $error("last free not one");

  property p_saturate;
    (cs_fall && !rw_reg && tx_cnt_next < 7'd49) |=> (so_reg[3:0] == 4'hf);
  endproperty
  a_saturate: assert property (p_saturate) else $error("count not saturated");

  property p_sleep_flush;
    sleep_enter |=> (tx_cnt == '0) && (rx_cnt == '0) && (state_reg == SLEEP_ST);
  endproperty
  a_sleep_flush: assert property (p_sleep_flush) else $error("sleep left data");

  property p_sleep_table;
    sleep_enter |=> (pa_table[1] == PA_RESET) && (pa_table[0] == $past(pa_table[0]));
  endproperty
  a_sleep_table: assert property (p_sleep_table) else $error("table sleep wrong");

  property p_pd_delayed;
    cs_active |=> (state_reg != SLEEP_ST);
  endproperty
  a_pd_delayed: assert property (p_pd_delayed) else $error("sleep while selected");

  property p_pin_so;
    cs_active |-> shared_status_pin_oe && (shared_status_pin_out == so_reg[7]);
  endproperty
  a_pin_so: assert property (p_pin_so) else $error("shared pin not output");

  property p_single_ends;
    (data_done && !burst_reg) |=> !data_phase_reg;
  endproperty
  a_single_ends: assert property (p_single_ends) else $error("single not ended");

  c_tx_burst: cover property (hdr_done && byte_in == HDR_TX_BURST ##[1:300] tx_push);
  c_rx_read: cover property (hdr_done && byte_in == HDR_RX_SINGLE ##[1:300] data_done);
  c_pin_tx: cover property (pin_cmd && {sclk_s, si_s} == PIN_TX ##1 state_reg == TX_ST);
  c_sleep: cover property (sleep_enter);
endmodule // radio_spi_port

// ===== spi_host.sv
// Purpose: Host model acting as mode-0 serial master of the radio port.
// Assumes: Link clock period 80 ns; link clock stands low between frames unless a pin-control code drives it high.
// Notes:   Data line shows the inverted last bit while deselected.
module spi_host (
  input  wire logic clk,
  input  wire logic so_line,
  output logic      sclk,
  output logic      si,
  output logic      cs_low
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle lines until the first frame
  initial begin
    sclk   = 1'b0;
    si     = 1'b0;
    cs_low = 1'b1;
  end

  // Select; the idle lines carry a pin-control code across the falling edge
  task automatic sel(input logic [1:0] code);
    sclk <= code[1];
    si   <= code[0];
    repeat (8) @(posedge clk);
    cs_low <= 1'b0;
    repeat (8) @(posedge clk);
    sclk <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  // Deselect ends a burst and clears the table index
  task automatic desel();
    repeat (8) @(posedge clk);
    cs_low <= 1'b1;
    si     <= ~si;
    repeat (16) @(posedge clk);
  endtask

  // One byte, MSB first; reply sampled at each rising link edge
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si <= tx[i];
      repeat (8) @(posedge clk);
      sclk  <= 1'b1;
      rx[i] = so_line;
      repeat (8) @(posedge clk);
      sclk <= 1'b0;
    end
  endtask
endmodule // spi_host

// ===== testbench.sv
// Purpose: Self-checking bench of the radio serial-port block.
// Assumes: Host model drives the link; bench plays radio side.
// Notes:   Oscillator-off is not exercised; receive flush only as a refused strobe.
module testbench
  import radio_spi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0, rst_n = 1'b0, so_hold = 1'b0;
  logic       st_en = 1'b0, st_lvl = 1'b0, pc_en = 1'b0, ser_en = 1'b0;
  logic       pin_a = 1'b0, fl_tx = 1'b0, fl_rx = 1'b0, slp = 1'b0, rdy = 1'b0, rvld = 1'b0;
  logic [2:0] pidx = 3'h0;
  logic [7:0] rdat = 8'h00, rx, pa, tdat;
  logic [3:0] rst_st;
  logic       sclk, si, csl, pin_out, pin_oe, tbit, tvld, rrdy, crl, so_line;
  int         n_errors = 0, num_checks = 0, n_out = 0;

  always #2.5 clk = ~clk;

  // Released pin shows the inverse of its last driven level
  always @(posedge clk) if (pin_oe) so_hold <= pin_out;
  assign so_line = pin_oe ? pin_out : ~so_hold;

  spi_host host (.clk(clk), .so_line(so_line), .sclk(sclk), .si(si), .cs_low(csl));

  radio_spi_port dut (.clk(clk), .rst_n(rst_n), .sclk_pin(sclk), .si_pin(si),
    .chip_select_low(csl), .shared_status_pin_out(pin_out),
    .shared_status_pin_oe(pin_oe), .status_pin_en(st_en), .status_pin_level(st_lvl),
    .pin_ctrl_en(pc_en), .serial_mode_en(ser_en), .general_pin_a(pin_a),
    .serial_tx_bit(tbit), .output_power_index(pidx), .pa_setting(pa),
    .flush_tx_strobe(fl_tx), .flush_rx_strobe(fl_rx), .sleep_req(slp),
    .osc_off_req(1'b0), .tx_out_data(tdat), .tx_out_valid(tvld),
    .tx_out_ready(rdy), .rx_in_data(rdat), .rx_in_valid(rvld),
    .rx_in_ready(rrdy), .radio_state(rst_st), .chip_ready_low(crl));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Radio side drains the output stage in order
  always @(posedge clk) if (tvld && rdy) begin
    chk(tdat, 8'(n_out + 16));
    n_out++;
  end

  // Watchdog
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    test_done();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk(rst_st, IDLE_ST);
    chk(pin_oe, 1'b0);
    st_en  <= 1'b1;
    st_lvl <= 1'b1;
    repeat (4) @(posedge clk);
    chk({pin_oe, pin_out}, 2'b11);
    host.sel(2'b00);
    chk(pin_oe, 1'b1);
    host.xfer(HDR_TX_BURST, rx);
    for (int i = 0; i <= FIFO_DEPTH; i++) begin
      host.xfer(8'(i + 16), rx);
      chk(rx, i < FIFO_DEPTH - 14 ? 8'h0f : 8'(FIFO_DEPTH - i));
    end
    host.desel();
    pc_en  <= 1'b1;
    rdy    <= 1'b1;
    ser_en <= 1'b1;
    pin_a  <= 1'b1;
    host.sel(PIN_TX);
    chk(rst_st, TX_ST);
    chk(tbit, 1'b1);
    host.desel();
    for (int k = 0; k < 400 && rst_st !== UND_ST; k++) @(posedge clk);
    chk(rst_st, UND_ST);
    chk(8'(n_out), 8'(FIFO_DEPTH));
    fl_tx <= 1'b1;
    @(posedge clk);
    fl_tx <= 1'b0;
    repeat (3) @(posedge clk);
    chk(rst_st, IDLE_ST);
    host.sel(PIN_RX);
    rvld <= 1'b1;
    rdat <= 8'ha5;
    @(posedge clk);
    rdat <= 8'h5a;
    @(posedge clk);
    rvld <= 1'b0;
    host.xfer(HDR_RX_SINGLE, rx);
    // Status is taken at the select edge, before the pin strobe moves the state
    chk(rx, 8'h0f);
    host.xfer(8'h00, rx);
    chk(rx, 8'ha5);
    host.xfer(HDR_RX_BURST, rx);
    chk(rx, 8'h11);
    host.xfer(8'h00, rx);
    chk(rx, 8'h5a);
    host.xfer(8'h00, rx);
    chk(rx, 8'h00);
    host.desel();
    // Refused receive flush outside idle; one byte is left for sleep to empty
    rdat <= 8'hc3;
    rvld <= 1'b1;
    @(posedge clk);
    rdat <= 8'h3c;
    @(posedge clk);
    rvld  <= 1'b0;
    fl_rx <= 1'b1;
    @(posedge clk);
    fl_rx <= 1'b0;
    host.sel(PIN_RX);
    host.xfer(HDR_RX_SINGLE, rx);
    chk(rx, 8'h1f);
    host.xfer(8'h00, rx);
    chk(rx, 8'hc3);
    host.desel();
    host.sel(PIN_IDLE);
    host.xfer(8'h7e, rx);
    for (int j = 0; j <= PA_ENTRIES; j++) host.xfer(8'(j + 8'h30), rx);
    host.desel();
    host.sel(PIN_IDLE);
    chk(rst_st, IDLE_ST);
    host.xfer(8'hfe, rx);
    for (int j = 0; j < PA_ENTRIES; j++) begin
      host.xfer(8'h00, rx);
      chk(rx, j == 0 ? 8'h38 : 8'(j + 8'h30));
    end
    host.desel();
    pidx <= 3'h3;
    repeat (3) @(posedge clk);
    chk(pa, 8'h33);
    host.sel(PIN_PD);
    chk(rst_st, IDLE_ST);
    host.desel();
    chk(rst_st, SLEEP_ST);
    chk(crl, 1'b1);
    chk(pa, 8'h00);
    pidx <= 3'h0;
    repeat (3) @(posedge clk);
    chk(pa, 8'h38);
    pc_en <= 1'b0;
    host.sel(2'b00);
    chk(rst_st, IDLE_ST);
    host.xfer(HDR_RX_SINGLE, rx);
    host.xfer(8'h00, rx);
    chk(rx, 8'h00);
    host.desel();
    test_done();
  end
endmodule // testbench
